// ---- src/sac_aux_port.sv ----
`include "sac_regs.svh"
module sac_aux_port
	import sac_pkg::*;
#(
	parameter int ERASE_CYCLES = `SAC_ERASE_HOLD_S * `SAC_CLK_HZ
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_panel_reset,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_code,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	output logic o_wr_reject,
	input wire logic [31:0] i_sched_pos,
	input wire logic [31:0] i_actual_pos,
	input wire logic [15:0] i_feed_forward_level,
	input wire logic i_length_step,
	input wire logic i_length_dir,
	input wire logic [31:0] i_correction_integral,
	input wire logic [31:0] i_line_rate,
	input wire logic [15:0] i_trip_cause,
	input wire logic [31:0] i_cut_length,
	input wire logic i_teach,
	input wire logic i_ready_to_cut,
	input wire logic i_cut_executed,
	input wire logic i_line_step,
	input wire logic i_line_index,
	input wire logic [15:0] i_hw_cmd,
	input wire logic [7:0] i_control_out,
	input wire logic i_exec_done,
	input wire logic i_param_valid,
	input wire logic i_program_run_switch,
	input wire logic i_key_a,
	output logic [15:0] o_cmd,
	output logic o_reload,
	output logic o_factory_erase
);
	logic [15:0] ctl_reg;
	logic [31:0] length_reg;
	logic [31:0] batch_reg;
	logic [31:0] scrap_reg;
	logic [31:0] abs_zero_reg;
	logic [31:0] err_min_reg;
	logic [31:0] err_max_reg;
	logic cut_window_reg;
	logic [31:0] spacing_cnt_reg;
	logic [31:0] spacing_reg;
	logic index_prev_reg;
	logic imm_prev_reg;
	logic dec_prev_reg;
	logic [31:0] rdata_next;
	logic [31:0] follow_err;
	logic [31:0] abs_pos;
	logic [15:0] code_bit;
	logic code_hit;
	logic wr_ok;
	logic [15:0] pulse_mask;
	logic dec_rise;
	logic imm_rise;
	logic index_rise;
	logic window_open;
	logic [31:0] batch_next;
	logic [31:0] scrap_next;
	logic boot_reg;
	logic [31:0] erase_cnt_reg;
	sac_erase_t erase_reg;

	assign follow_err = i_sched_pos - i_actual_pos;
	assign abs_pos = i_actual_pos - abs_zero_reg;
	assign pulse_mask = `SAC_PULSE_MASK;
	// A write is taken only when the range checker passes its data.
	assign wr_ok = i_wr && i_param_valid;
	// Counted commands act once, on the rising edge of the effective bit.
	assign dec_rise = o_cmd[`SAC_BIT_DEC_BATCH] && !dec_prev_reg;
	assign imm_rise = o_cmd[`SAC_BIT_IMM_CUT] && !imm_prev_reg;
	assign index_rise = i_line_index && !index_prev_reg;
	assign window_open = i_ready_to_cut && !cut_window_reg;

	always_comb begin
		code_bit = 16'h0000;
		code_hit = 1'b1;
		case (i_code)
			`SAC_CODE_LEN_SEL: code_bit[`SAC_BIT_LEN_SEL] = 1'b1;
			`SAC_CODE_READ_PI: code_bit[`SAC_BIT_READ_PI] = 1'b1;
			`SAC_CODE_CUT_DONE: code_bit[`SAC_BIT_CUT_DONE] = 1'b1;
			`SAC_CODE_START: code_bit[`SAC_BIT_START] = 1'b1;
			`SAC_CODE_IMM_CUT: code_bit[`SAC_BIT_IMM_CUT] = 1'b1;
			`SAC_CODE_RESET: code_bit[`SAC_BIT_RESET] = 1'b1;
			`SAC_CODE_SET_ZERO: code_bit[`SAC_BIT_SET_ZERO] = 1'b1;
			`SAC_CODE_DEC_BATCH: code_bit[`SAC_BIT_DEC_BATCH] = 1'b1;
			`SAC_CODE_JOG_FWD: code_bit[`SAC_BIT_JOG_FWD] = 1'b1;
			`SAC_CODE_JOG_BWD: code_bit[`SAC_BIT_JOG_BWD] = 1'b1;
			`SAC_CODE_ACT_DATA: code_bit[`SAC_BIT_ACT_DATA] = 1'b1;
			`SAC_CODE_STORE: code_bit[`SAC_BIT_STORE] = 1'b1;
			default: code_hit = 1'b0;
		endcase
	end

	// Effective commands combine serial and hardware sources.
	assign o_cmd = ctl_reg | i_hw_cmd;

	// Each control bit is written, cleared or self-cleared on its own.
	for (genvar b = 0; b < $bits(ctl_reg); b++) begin : g_ctl
		always_ff @(posedge i_clk) begin
			if (i_srst || o_reload) begin
				ctl_reg[b] <= 1'b0;
			end else if (wr_ok && i_code == `SAC_CODE_CONTROL) begin
				ctl_reg[b] <= i_wdata[b];
			end else if (wr_ok && code_hit && code_bit[b]) begin
				ctl_reg[b] <= i_wdata[0];
			end else if (i_exec_done && pulse_mask[b]) begin
				ctl_reg[b] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			imm_prev_reg <= 1'b0;
		end else begin
			imm_prev_reg <= o_cmd[`SAC_BIT_IMM_CUT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			dec_prev_reg <= 1'b0;
		end else begin
			dec_prev_reg <= o_cmd[`SAC_BIT_DEC_BATCH];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload || o_cmd[`SAC_BIT_RESET]) begin
			length_reg <= 32'h0000_0000;
		end else if (i_length_step) begin
			if (i_length_dir) begin
				length_reg <= length_reg - 32'h0000_0001;
			end else begin
				length_reg <= length_reg + 32'h0000_0001;
			end
		end
	end

	// A preset wins over a count; a cut and a decrement together cancel.
	always_comb begin
		batch_next = batch_reg;
		if (wr_ok && i_code == `SAC_CODE_BATCH) begin
			batch_next = i_wdata;
		end else if (i_cut_executed && !dec_rise) begin
			batch_next = batch_reg + 32'h0000_0001;
		end else if (!i_cut_executed && dec_rise) begin
			batch_next = batch_reg - 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			batch_reg <= 32'h0000_0000;
		end else begin
			batch_reg <= batch_next;
		end
	end

	always_comb begin
		scrap_next = scrap_reg;
		if (wr_ok && i_code == `SAC_CODE_SCRAP) begin
			scrap_next = i_wdata;
		end else if (imm_rise) begin
			scrap_next = scrap_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			scrap_reg <= 32'h0000_0000;
		end else begin
			scrap_reg <= scrap_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			abs_zero_reg <= 32'h0000_0000;
		end else if (i_teach || o_cmd[`SAC_BIT_SET_ZERO]) begin
			abs_zero_reg <= i_actual_pos;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			cut_window_reg <= 1'b0;
		end else if (window_open) begin
			cut_window_reg <= 1'b1;
		end else if (cut_window_reg && o_cmd[`SAC_BIT_CUT_DONE]) begin
			cut_window_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			err_min_reg <= 32'h0000_0000;
		end else if (window_open) begin
			err_min_reg <= follow_err;
		end else if (cut_window_reg &&
				$signed(follow_err) < $signed(err_min_reg)) begin
			err_min_reg <= follow_err;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			err_max_reg <= 32'h0000_0000;
		end else if (window_open) begin
			err_max_reg <= follow_err;
		end else if (cut_window_reg &&
				$signed(follow_err) > $signed(err_max_reg)) begin
			err_max_reg <= follow_err;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			index_prev_reg <= 1'b0;
		end else begin
			index_prev_reg <= i_line_index;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			spacing_reg <= 32'h0000_0000;
		end else if (index_rise) begin
			spacing_reg <= spacing_cnt_reg;
		end
	end

	// The step that lands with the index edge starts the new count.
	always_ff @(posedge i_clk) begin
		if (i_srst || o_reload) begin
			spacing_cnt_reg <= 32'h0000_0000;
		end else if (index_rise) begin
			spacing_cnt_reg <= {31'h0000_0000, i_line_step};
		end else if (i_line_step) begin
			spacing_cnt_reg <= spacing_cnt_reg + 32'h0000_0001;
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (i_code)
			`SAC_CODE_FOLLOW_ERR: rdata_next = follow_err;
			`SAC_CODE_FF_LEVEL: rdata_next = {16'h0000,
				i_feed_forward_level & `SAC_FF_MAX};
			`SAC_CODE_LENGTH: rdata_next = length_reg;
			`SAC_CODE_CARR_POS: rdata_next = i_actual_pos;
			`SAC_CODE_INTEGRAL: rdata_next = i_correction_integral;
			`SAC_CODE_BATCH: rdata_next = batch_reg;
			`SAC_CODE_SCRAP: rdata_next = scrap_reg;
			`SAC_CODE_LINE_RATE: rdata_next = i_line_rate;
			`SAC_CODE_TRIP: rdata_next = {16'h0000, i_trip_cause};
			`SAC_CODE_ABS_POS: rdata_next = abs_pos;
			`SAC_CODE_ERR_MIN: rdata_next = err_min_reg;
			`SAC_CODE_ERR_MAX: rdata_next = err_max_reg;
			`SAC_CODE_CUT_LEN: rdata_next = i_cut_length;
			`SAC_CODE_INDEX_SPACING: rdata_next = spacing_reg;
			`SAC_CODE_STATUS: rdata_next = {24'h00_0000, i_control_out};
			`SAC_CODE_CONTROL: rdata_next = {16'h0000, ctl_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= rdata_next;
		end
	end

	// Writes of data the parameter checker flags invalid are refused.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_wr_reject <= 1'b0;
		end else begin
			o_wr_reject <= i_wr && !i_param_valid;
		end
	end

	// Panel reset or power-up asks for a reload of stored settings.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
		end
	end
	assign o_reload = boot_reg || i_panel_reset;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			erase_reg <= SAC_ERASE_IDLE;
		end else begin
			case (erase_reg)
				SAC_ERASE_IDLE: begin
					if (boot_reg && i_program_run_switch && i_key_a) begin
						erase_reg <= SAC_ERASE_HOLD;
					end else if (boot_reg) begin
						erase_reg <= SAC_ERASE_DONE;
					end
				end
				SAC_ERASE_HOLD: begin
					if (!i_key_a || !i_program_run_switch) begin
						erase_reg <= SAC_ERASE_DONE;
					end else if (erase_cnt_reg == ERASE_CYCLES - 1) begin
						erase_reg <= SAC_ERASE_DONE;
					end
				end
				SAC_ERASE_DONE: erase_reg <= SAC_ERASE_DONE;
				default: erase_reg <= SAC_ERASE_IDLE;
			endcase
		end
	end

	// The hold time is counted only while the erase request stands.
	always_ff @(posedge i_clk) begin
		if (i_srst || erase_reg != SAC_ERASE_HOLD) begin
			erase_cnt_reg <= 32'h0000_0000;
		end else begin
			erase_cnt_reg <= erase_cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_factory_erase <= 1'b0;
		end else begin
			o_factory_erase <= erase_reg == SAC_ERASE_HOLD && i_key_a &&
				i_program_run_switch &&
				erase_cnt_reg == ERASE_CYCLES - 1;
		end
	end
endmodule

// ---- src/sac_pkg.sv ----
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_ERASE_IDLE = 2'b00,
		SAC_ERASE_HOLD = 2'b01,
		SAC_ERASE_DONE = 2'b10
	} sac_erase_t;
endpackage

// ---- src/sac_regs.svh ----
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_CODE_FOLLOW_ERR 8'h01
`define SAC_CODE_FF_LEVEL 8'h02
`define SAC_CODE_LENGTH 8'h03
`define SAC_CODE_CARR_POS 8'h04
`define SAC_CODE_INTEGRAL 8'h05
`define SAC_CODE_BATCH 8'h07
`define SAC_CODE_SCRAP 8'h08
`define SAC_CODE_LINE_RATE 8'h09
`define SAC_CODE_TRIP 8'h10
`define SAC_CODE_ABS_POS 8'h12
`define SAC_CODE_ERR_MIN 8'h15
`define SAC_CODE_ERR_MAX 8'h16
`define SAC_CODE_CUT_LEN 8'h24
`define SAC_CODE_INDEX_SPACING 8'h25
`define SAC_CODE_LEN_SEL 8'h37
`define SAC_CODE_READ_PI 8'h38
`define SAC_CODE_CUT_DONE 8'h39
`define SAC_CODE_START 8'h3A
`define SAC_CODE_IMM_CUT 8'h3B
`define SAC_CODE_RESET 8'h3C
`define SAC_CODE_SET_ZERO 8'h3D
`define SAC_CODE_DEC_BATCH 8'h3E
`define SAC_CODE_JOG_FWD 8'h41
`define SAC_CODE_JOG_BWD 8'h42
`define SAC_CODE_ACT_DATA 8'h43
`define SAC_CODE_STORE 8'h44
`define SAC_CODE_STATUS 8'h55
`define SAC_CODE_CONTROL 8'h56
`define SAC_BIT_START 0
`define SAC_BIT_STORE 1
`define SAC_BIT_CUT_DONE 2
`define SAC_BIT_ACT_DATA 3
`define SAC_BIT_READ_PI 4
`define SAC_BIT_JOG_BWD 5
`define SAC_BIT_JOG_FWD 6
`define SAC_BIT_RESET 7
`define SAC_BIT_DEC_BATCH 12
`define SAC_BIT_SET_ZERO 13
`define SAC_BIT_LEN_SEL 14
`define SAC_BIT_IMM_CUT 15
`define SAC_PULSE_MASK 16'h801A
`define SAC_LEVEL_MASK 16'h70E5
`define SAC_FF_MAX 16'h0FFF
`define SAC_ERASE_HOLD_S 5
`define SAC_CLK_HZ 200000000
`endif

// ---- verification/sac_aux_port_asserts.sv ----
`include "sac_regs.svh"
module sac_aux_port_asserts #(
	parameter int ERASE_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_panel_reset,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_code,
	input wire logic [31:0] i_wdata,
	input wire logic [31:0] o_rdata,
	input wire logic o_wr_reject,
	input wire logic [15:0] i_feed_forward_level,
	input wire logic [15:0] i_trip_cause,
	input wire logic [15:0] i_hw_cmd,
	input wire logic [7:0] i_control_out,
	input wire logic i_exec_done,
	input wire logic i_param_valid,
	input wire logic i_program_run_switch,
	input wire logic i_key_a,
	input wire logic [15:0] o_cmd,
	input wire logic o_reload,
	input wire logic o_factory_erase
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	property p_ff;
		i_rd && i_code == `SAC_CODE_FF_LEVEL |=>
			o_rdata == {20'h0, $past(i_feed_forward_level[11:0])};
	endproperty
	a_ff: assert property (p_ff) else $error("ff level read");
	property p_trip;
		i_rd && i_code == `SAC_CODE_TRIP |=>
			o_rdata == {16'h0, $past(i_trip_cause)};
	endproperty
	a_trip: assert property (p_trip) else $error("trip read");
	property p_stat;
		i_rd && i_code == `SAC_CODE_STATUS |=>
			o_rdata == {24'h0, $past(i_control_out)};
	endproperty
	a_stat: assert property (p_stat) else $error("status read");
	property p_or;
		(o_cmd & i_hw_cmd) == i_hw_cmd;
	endproperty
	a_or: assert property (p_or) else $error("cmd or");
	property p_clr;
		i_exec_done && !i_wr |=>
			(o_cmd & ~i_hw_cmd & `SAC_PULSE_MASK) == 16'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("pulse clear");
	property p_ctl;
		i_wr && i_param_valid && i_code == `SAC_CODE_CONTROL &&
			!o_reload |=>
			(o_cmd & $past(i_wdata[15:0]) & `SAC_LEVEL_MASK)
			== ($past(i_wdata[15:0]) & `SAC_LEVEL_MASK);
	endproperty
	a_ctl: assert property (p_ctl) else $error("ctl write");
	property p_rej;
		i_wr && !i_param_valid && !o_reload |=> o_wr_reject;
	endproperty
	a_rej: assert property (p_rej) else $error("reject");
	property p_rld;
		i_panel_reset |-> o_reload;
	endproperty
	a_rld: assert property (p_rld) else $error("reload");
	property p_era;
		o_factory_erase |-> $past(i_key_a) && $past(i_program_run_switch);
	endproperty
	a_era: assert property (p_era) else $error("erase");
	c_era: cover property (o_factory_erase);
	c_rej: cover property (o_wr_reject);
	c_clr: cover property (i_exec_done);
endmodule
bind sac_aux_port sac_aux_port_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
	.i_clk, .i_srst, .i_panel_reset, .i_wr, .i_rd, .i_code, .i_wdata,
	.o_rdata, .o_wr_reject, .i_feed_forward_level, .i_trip_cause,
	.i_hw_cmd, .i_control_out, .i_exec_done, .i_param_valid,
	.i_program_run_switch, .i_key_a, .o_cmd, .o_reload, .o_factory_erase
);

// ---- verification/sac_exec_model.sv ----
`include "sac_regs.svh"
module sac_exec_model (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [15:0] i_cmd,
	input wire logic [3:0] i_delay,
	output logic o_exec_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_reg;
	// Acknowledges pending pulse commands after a set delay.
	always_ff @(posedge i_clk) begin
		if (i_srst || (i_cmd & `SAC_PULSE_MASK) == 16'h0) begin
			cnt_reg <= 4'h0;
			o_exec_done <= 1'b0;
		end else begin
			o_exec_done <= (cnt_reg == i_delay);
			cnt_reg <= (cnt_reg == i_delay) ? 4'h0 : cnt_reg + 4'h1;
		end
	end
endmodule

// ---- verification/test_sac_aux_port.sv ----
`include "sac_regs.svh"
module test_sac_aux_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 1'b0, i_srst = 1'b1, i_panel_reset = 1'b0;
	logic i_wr = 1'b0, i_rd = 1'b0, i_length_step = 1'b0;
	logic i_length_dir = 1'b0, i_teach = 1'b0, i_ready_to_cut = 1'b0;
	logic i_cut_executed = 1'b0, i_line_step = 1'b0, i_line_index = 1'b0;
	logic i_param_valid = 1'b1, i_program_run_switch = 1'b1, i_key_a = 1'b1;
	logic [7:0] i_code = 8'h0, i_control_out = 8'h0;
	logic [31:0] i_wdata = 32'h0, i_sched_pos = 32'h0, i_actual_pos = 32'h0;
	logic [31:0] i_correction_integral = 32'h0, i_line_rate = 32'h0;
	logic [31:0] i_cut_length = 32'h0, o_rdata, v;
	logic [15:0] i_feed_forward_level = 16'h0, i_trip_cause = 16'h0;
	logic [15:0] i_hw_cmd = 16'h0, o_cmd;
	logic o_rvalid, o_wr_reject, o_reload, o_factory_erase, i_exec_done;
	logic [3:0] dly = 4'h0;
	logic [31:0] expq[$];
	int n_fail = 0, check_count = 0, n_erase = 0;
	sac_aux_port #(.ERASE_CYCLES(10)) uut (
		.i_clk, .i_srst, .i_panel_reset, .i_wr, .i_rd, .i_code, .i_wdata,
		.o_rdata, .o_rvalid, .o_wr_reject, .i_sched_pos, .i_actual_pos,
		.i_feed_forward_level, .i_length_step, .i_length_dir,
		.i_correction_integral, .i_line_rate, .i_trip_cause, .i_cut_length,
		.i_teach, .i_ready_to_cut, .i_cut_executed, .i_line_step,
		.i_line_index, .i_hw_cmd, .i_control_out, .i_exec_done,
		.i_param_valid, .i_program_run_switch, .i_key_a, .o_cmd, .o_reload,
		.o_factory_erase
	);
	sac_exec_model u_exec (.i_clk, .i_srst, .i_cmd(o_cmd), .i_delay(dly),
		.o_exec_done(i_exec_done));
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [31:0] d);
		@(posedge i_clk);
		i_code <= c;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] c, input logic [31:0] e);
		@(posedge i_clk);
		expq.push_back(e);
		i_code <= c;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task automatic end_sim;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(negedge i_clk) begin
		if (o_factory_erase === 1'b1) n_erase++;
		if (o_rvalid === 1'b1) begin
			if (expq.size() == 0) chk(32'h1, 32'h0);
			else chk(o_rdata, expq.pop_front());
		end
	end
	initial begin
		#400000;
		n_fail++;
		end_sim();
	end
	initial begin
		void'($urandom(32'hD07EDDDD));
		repeat (5) @(posedge i_clk);
		i_srst <= 1'b0;
		repeat (30) @(posedge i_clk);
		chk(n_erase, 1);
		i_key_a <= 1'b0;
		$display("erase test done");
		i_sched_pos <= $urandom();
		i_actual_pos <= $urandom();
		i_feed_forward_level <= 16'($urandom());
		i_correction_integral <= $urandom();
		i_trip_cause <= 16'($urandom());
		i_control_out <= 8'($urandom());
		{i_teach, i_line_index, i_line_step, i_ready_to_cut} <= 4'($urandom());
		dly <= 4'($urandom());
		@(posedge i_clk);
		rd(`SAC_CODE_FOLLOW_ERR, i_sched_pos - i_actual_pos);
		rd(`SAC_CODE_FF_LEVEL, {20'h0, i_feed_forward_level[11:0]});
		rd(`SAC_CODE_INTEGRAL, i_correction_integral);
		rd(`SAC_CODE_TRIP, {16'h0, i_trip_cause});
		rd(`SAC_CODE_STATUS, {24'h0, i_control_out});
		rd(8'hFF, 32'h0);
		$display("read test done");
		v = $urandom();
		{i_teach, i_ready_to_cut, i_line_step, i_line_index} <= 4'h8;
		i_actual_pos <= v;
		@(posedge i_clk) i_teach <= 1'b0;
		i_actual_pos <= v + 32'h40;
		rd(`SAC_CODE_ABS_POS, 32'h40);
		rd(`SAC_CODE_CARR_POS, v + 32'h40);
		@(posedge i_clk) i_line_index <= 1'b1;
		@(posedge i_clk) i_line_index <= 1'b0;
		v = $urandom_range(8, 1);
		repeat (v) begin
			@(posedge i_clk) i_line_step <= 1'b1;
			@(posedge i_clk) i_line_step <= 1'b0;
		end
		@(posedge i_clk) i_line_index <= 1'b1;
		@(posedge i_clk) i_line_index <= 1'b0;
		rd(`SAC_CODE_INDEX_SPACING, v);
		wr(`SAC_CODE_CUT_DONE, 32'h1);
		wr(`SAC_CODE_CUT_DONE, 32'h0);
		i_actual_pos <= 32'h0;
		i_sched_pos <= 32'hA;
		i_ready_to_cut <= 1'b1;
		@(posedge i_clk) i_ready_to_cut <= 1'b0;
		i_sched_pos <= 32'hFFFF_FFFB;
		@(posedge i_clk) i_sched_pos <= 32'h14;
		wr(`SAC_CODE_CUT_DONE, 32'h1);
		wr(`SAC_CODE_CUT_DONE, 32'h0);
		i_sched_pos <= 32'h64;
		rd(`SAC_CODE_ERR_MIN, 32'hFFFF_FFFB);
		rd(`SAC_CODE_ERR_MAX, 32'h14);
		$display("position test done");
		v = $urandom() & 32'h70E5;
		i_hw_cmd <= 16'($urandom()) & `SAC_LEVEL_MASK;
		wr(`SAC_CODE_CONTROL, v);
		@(negedge i_clk) chk({16'h0, o_cmd}, v | i_hw_cmd);
		wr(`SAC_CODE_CONTROL, 32'h0);
		@(negedge i_clk) chk({16'h0, o_cmd}, {16'h0, i_hw_cmd});
		i_hw_cmd <= 16'h0;
		$display("command test done");
		v = $urandom() & 32'hFFFF;
		wr(`SAC_CODE_BATCH, v);
		@(posedge i_clk) i_cut_executed <= 1'b1;
		@(posedge i_clk) i_cut_executed <= 1'b0;
		rd(`SAC_CODE_BATCH, v + 1);
		wr(`SAC_CODE_DEC_BATCH, 32'h1);
		wr(`SAC_CODE_DEC_BATCH, 32'h0);
		rd(`SAC_CODE_BATCH, v);
		wr(`SAC_CODE_SCRAP, v);
		wr(`SAC_CODE_IMM_CUT, 32'h1);
		for (int i = 0; i < 40 && o_cmd[15] !== 1'b0; i++) @(posedge i_clk);
		chk({31'h0, o_cmd[15]}, 32'h0);
		rd(`SAC_CODE_SCRAP, v + 1);
		wr(`SAC_CODE_RESET, 32'h1);
		wr(`SAC_CODE_RESET, 32'h0);
		repeat (3) begin
			@(posedge i_clk) i_length_step <= 1'b1;
			@(posedge i_clk) i_length_step <= 1'b0;
		end
		rd(`SAC_CODE_LENGTH, 32'h3);
		wr(`SAC_CODE_RESET, 32'h1);
		rd(`SAC_CODE_LENGTH, 32'h0);
		wr(`SAC_CODE_RESET, 32'h0);
		$display("counter test done");
		i_param_valid <= 1'b0;
		wr(`SAC_CODE_SCRAP, 32'h5);
		i_param_valid <= 1'b1;
		@(negedge i_clk) chk({31'h0, o_wr_reject}, 32'h1);
		rd(`SAC_CODE_SCRAP, v + 1);
		@(posedge i_clk) i_panel_reset <= 1'b1;
		@(negedge i_clk) chk({31'h0, o_reload}, 32'h1);
		@(posedge i_clk) i_panel_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		rd(`SAC_CODE_BATCH, 32'h0);
		for (int i = 0; i < 10 && expq.size() != 0; i++) @(posedge i_clk);
		chk(expq.size(), 0);
		$display("reset test done");
		end_sim();
	end
endmodule
